// >>> hw/tlc_params.svh
// Register offsets, field positions, reset values and codes of the transmitter link config bank
// Notes on behaviour
// - Registers read and written over AXI4-Lite, soft reset and scrambler restart write-only
// - Status bits may show old or new
// - Multi-bit writes announced by a toggle
// - Undefined bits read as zero
// - Link rate codes 0x06, 0x0a, 0x14
// - Lane count field five bits, 1/2/4
// - Framing bit selects enhanced framing
// - Two-bit training pattern code
// - Two-bit link quality pattern code
// - Scrambler bypass sends symbols unscrambled
// - Soft reset write-only, per-stream pulses
// - Transmitter off means stuffing on lanes
// - Video off means blanking ID, NoVideo
// - Video enable applied at frame boundary
// - Side channel enable gates secondary data
// - Scrambler restart write-only, reads zero
// - Multi-stream enable bit zero
// - Payload-updated bit read-only, set by hardware
// - Pixel width programmed per stream
`ifndef TLC_PARAMS_SVH
`define TLC_PARAMS_SVH
`define TLC_OFF_RATE 12'h000
`define TLC_OFF_LANES 12'h004
`define TLC_OFF_FRAMING 12'h008
`define TLC_OFF_TRAIN 12'h00c
`define TLC_OFF_QUAL 12'h010
`define TLC_OFF_SCR_BYP 12'h014
`define TLC_OFF_SPREAD 12'h018
`define TLC_OFF_SRST 12'h01c
`define TLC_OFF_LINK_EN 12'h080
`define TLC_OFF_VID_EN 12'h084
`define TLC_OFF_SIDE_EN 12'h088
`define TLC_OFF_SCR_RST 12'h0c0
`define TLC_OFF_MST 12'h0d0
`define TLC_OFF_PIXW 12'h0e0
`define TLC_RATE_162 8'h06
`define TLC_RATE_270 8'h0a
`define TLC_RATE_540 8'h14
`define TLC_RST_RATE 8'h06
`define TLC_RST_LANES 5'h01
`define TLC_RST_PIXW 8'h55
`define TLC_MST_EN_BIT 0
`define TLC_MST_VCP_BIT 1
`define TLC_RESP_OKAY 2'h0
`define TLC_RESP_SLVERR 2'h2
`endif

// >>> hw/tlc_pkg.sv
// Types shared by the transmitter link config bank
package tlc_pkg;
    typedef enum logic [1:0] {
        TLC_TRAIN_OFF = 2'b00,
        TLC_TRAIN_TPS1 = 2'b01,
        TLC_TRAIN_TPS2 = 2'b10,
        TLC_TRAIN_TPS3 = 2'b11
    } tlc_train_t;

    typedef enum logic [1:0] {
        TLC_QUAL_NONE = 2'b00,
        TLC_QUAL_D102 = 2'b01,
        TLC_QUAL_SERM = 2'b10,
        TLC_QUAL_PRBS7 = 2'b11
    } tlc_qual_t;

    // Multi-bit settings handed to the link domain as one word
    typedef struct packed {
        logic [7:0] rate;
        logic [4:0] lanes;
        tlc_train_t train;
        tlc_qual_t qual;
        // One pixel width byte per stream, stream 1 in the low byte
        logic [3:0][7:0] pixw;
    } tlc_cfg_t;

    // Single-bit settings
    typedef struct packed {
        logic enh_frame;
        logic scr_bypass;
        logic spread;
        logic link_en;
        logic vid_en;
        logic side_en;
        logic mst_en;
    } tlc_bits_t;

    typedef struct packed {
        logic awdone;
        logic [11:0] awaddr;
        logic wdone;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        tlc_cfg_t cfg;
        tlc_bits_t bits;
        logic vcp_done;
        logic cfg_tgl;
        logic [3:0] srst_pulse;
        logic scr_pulse;
        logic vid_applied;
    } tlc_state_t;
endpackage

// >>> hw/tlc_regs.sv
// AXI4-Lite register bank for the transmitter link configuration
`timescale 1ns/100ps
`include "tlc_params.svh"
module tlc_regs
(
    input wire logic clk, // Register clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [31:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic vsync_in, // Vertical sync pin, frame boundary
    input wire logic vcp_updated_in, // Payload-updated status from sink
    output tlc_pkg::tlc_cfg_t cfg_out, // Multi-bit settings
    output logic cfg_toggle, // Toggles when cfg_out changes
    output tlc_pkg::tlc_bits_t bits_out, // Single-bit settings
    output logic [3:0] stream_reset, // One-cycle per-stream video reset
    output logic scrambler_restart, // One-cycle scrambler reset
    output logic send_stuffing, // Lanes carry stuffing only
    output logic send_novideo // Lanes carry blanking ID, NoVideo
);
    tlc_pkg::tlc_state_t s_r;
    tlc_pkg::tlc_state_t s_nxt;
    logic vs_m_r;
    logic vs_s_r;
    logic vs_d_r;
    logic vcp_m_r;
    logic vcp_s_r;
    logic wr_go;
    logic rd_go;
    logic vs_edge;
    logic [11:0] raddr;
    logic [31:0] wd;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vs_m_r <= 1'b0;
            vs_s_r <= 1'b0;
            vs_d_r <= 1'b0;
            vcp_m_r <= 1'b0;
            vcp_s_r <= 1'b0;
        end
        else
        begin
            vs_m_r <= vsync_in;
            vs_s_r <= vs_m_r;
            vs_d_r <= vs_s_r;
            vcp_m_r <= vcp_updated_in;
            vcp_s_r <= vcp_m_r;
        end
    end

    assign vs_edge = vs_s_r & ~vs_d_r;

    // ==========================================================
    // Handshakes
    assign s_axi_awready = ~s_r.awdone & ~s_r.bvalid;
    assign s_axi_wready = ~s_r.wdone & ~s_r.bvalid;
    assign s_axi_arready = ~s_r.rvalid;
    assign wr_go = s_r.awdone & s_r.wdone & ~s_r.bvalid;
    assign rd_go = s_axi_arvalid & ~s_r.rvalid;
    assign raddr = {s_axi_araddr[11:2], 2'b00};

    // Strobe-merged write word for a given current value
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d,
        input logic [3:0] st);
        logic [31:0] m;
        m = cur;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ==========================================================
    // Read mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (raddr)
            `TLC_OFF_RATE: rd_word[7:0] = s_r.cfg.rate;
            `TLC_OFF_LANES: rd_word[4:0] = s_r.cfg.lanes;
            `TLC_OFF_FRAMING: rd_word[0] = s_r.bits.enh_frame;
            `TLC_OFF_TRAIN: rd_word[1:0] = s_r.cfg.train;
            `TLC_OFF_QUAL: rd_word[1:0] = s_r.cfg.qual;
            `TLC_OFF_SCR_BYP: rd_word[0] = s_r.bits.scr_bypass;
            `TLC_OFF_SPREAD: rd_word[0] = s_r.bits.spread;
            `TLC_OFF_SRST: rd_word = 32'h0000_0000;
            `TLC_OFF_LINK_EN: rd_word[0] = s_r.bits.link_en;
            `TLC_OFF_VID_EN: rd_word[0] = s_r.bits.vid_en;
            `TLC_OFF_SIDE_EN: rd_word[0] = s_r.bits.side_en;
            `TLC_OFF_SCR_RST: rd_word = 32'h0000_0000;
            `TLC_OFF_MST:
            begin
                rd_word[`TLC_MST_EN_BIT] = s_r.bits.mst_en;
                rd_word[`TLC_MST_VCP_BIT] = s_r.vcp_done;
            end
            `TLC_OFF_PIXW: rd_word = s_r.cfg.pixw;
            default: rd_hit = 1'b0;
        endcase
    end

    assign wr_hit = (s_r.awaddr == `TLC_OFF_RATE) || (s_r.awaddr == `TLC_OFF_LANES)
        || (s_r.awaddr == `TLC_OFF_FRAMING) || (s_r.awaddr == `TLC_OFF_TRAIN)
        || (s_r.awaddr == `TLC_OFF_QUAL) || (s_r.awaddr == `TLC_OFF_SCR_BYP)
        || (s_r.awaddr == `TLC_OFF_SPREAD) || (s_r.awaddr == `TLC_OFF_SRST)
        || (s_r.awaddr == `TLC_OFF_LINK_EN) || (s_r.awaddr == `TLC_OFF_VID_EN)
        || (s_r.awaddr == `TLC_OFF_SIDE_EN) || (s_r.awaddr == `TLC_OFF_SCR_RST)
        || (s_r.awaddr == `TLC_OFF_MST) || (s_r.awaddr == `TLC_OFF_PIXW);

    // ==========================================================
    // Next state
    always_comb
    begin
        s_nxt = s_r;
        wd = 32'h0000_0000;
        s_nxt.srst_pulse = 4'h0;
        s_nxt.scr_pulse = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.awdone = 1'b1;
            s_nxt.awaddr = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.wdone = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
        begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            s_nxt.awdone = 1'b0;
            s_nxt.wdone = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_hit ? `TLC_RESP_OKAY : `TLC_RESP_SLVERR;
            unique case (s_r.awaddr)
                `TLC_OFF_RATE:
                begin
                    wd = merge({24'h0, s_r.cfg.rate}, s_r.wdata, s_r.wstrb);
                    s_nxt.cfg.rate = wd[7:0];
                end
                `TLC_OFF_LANES:
                begin
                    wd = merge({27'h0, s_r.cfg.lanes}, s_r.wdata, s_r.wstrb);
                    s_nxt.cfg.lanes = wd[4:0];
                end
                `TLC_OFF_TRAIN:
                begin
                    wd = merge({30'h0, s_r.cfg.train}, s_r.wdata, s_r.wstrb);
                    s_nxt.cfg.train = tlc_pkg::tlc_train_t'(wd[1:0]);
                end
                `TLC_OFF_QUAL:
                begin
                    wd = merge({30'h0, s_r.cfg.qual}, s_r.wdata, s_r.wstrb);
                    s_nxt.cfg.qual = tlc_pkg::tlc_qual_t'(wd[1:0]);
                end
                `TLC_OFF_PIXW:
                begin
                    wd = merge(s_r.cfg.pixw, s_r.wdata, s_r.wstrb);
                    s_nxt.cfg.pixw = wd;
                end
                default:
                begin
                    if (s_r.wstrb[0])
                    begin
                        unique case (s_r.awaddr)
                            `TLC_OFF_FRAMING: s_nxt.bits.enh_frame = s_r.wdata[0];
                            `TLC_OFF_SCR_BYP: s_nxt.bits.scr_bypass = s_r.wdata[0];
                            `TLC_OFF_SPREAD: s_nxt.bits.spread = s_r.wdata[0];
                            `TLC_OFF_SRST: s_nxt.srst_pulse = s_r.wdata[3:0];
                            `TLC_OFF_LINK_EN: s_nxt.bits.link_en = s_r.wdata[0];
                            `TLC_OFF_VID_EN: s_nxt.bits.vid_en = s_r.wdata[0];
                            `TLC_OFF_SIDE_EN: s_nxt.bits.side_en = s_r.wdata[0];
                            `TLC_OFF_SCR_RST: s_nxt.scr_pulse = s_r.wdata[0];
                            `TLC_OFF_MST: s_nxt.bits.mst_en = s_r.wdata[0];
                            default: s_nxt.bits = s_r.bits;
                        endcase
                    end
                end
            endcase
        end
        // Announce any change of the multi-bit word
        if (s_nxt.cfg != s_r.cfg)
        begin
            s_nxt.cfg_tgl = ~s_r.cfg_tgl;
        end
        // Sticky until multi-stream is disabled; the status set wins
        if (!s_nxt.bits.mst_en)
        begin
            s_nxt.vcp_done = 1'b0;
        end
        if (vcp_s_r)
        begin
            s_nxt.vcp_done = 1'b1;
        end
        // Video enable takes effect only at a frame start
        if (vs_edge)
        begin
            s_nxt.vid_applied = s_r.bits.vid_en;
        end
        if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_go)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = rd_hit ? `TLC_RESP_OKAY : `TLC_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.cfg.rate <= `TLC_RST_RATE;
            s_r.cfg.lanes <= `TLC_RST_LANES;
            s_r.cfg.pixw <= {4{`TLC_RST_PIXW}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign cfg_out = s_r.cfg;
    assign cfg_toggle = s_r.cfg_tgl;
    assign bits_out = s_r.bits;
    assign stream_reset = s_r.srst_pulse;
    assign scrambler_restart = s_r.scr_pulse;
    assign send_stuffing = ~s_r.bits.link_en;
    assign send_novideo = s_r.bits.link_en & ~s_r.vid_applied;
endmodule

// >>> sim/tlc_regs_chk.sv
// Concurrent checks on the transmitter link config bank ports
`timescale 1ns/100ps
module tlc_regs_chk
(
    input wire logic clk, // Register clock
    input wire logic rst, // Async reset
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_arready, // Ar ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic vsync_in, // Frame sync
    input wire tlc_pkg::tlc_cfg_t cfg_out, // Settings
    input wire logic cfg_toggle, // Change toggle
    input wire tlc_pkg::tlc_bits_t bits_out, // Enables
    input wire logic [3:0] stream_reset, // Stream resets
    input wire logic scrambler_restart, // Scrambler reset
    input wire logic send_stuffing, // Stuffing only
    input wire logic send_novideo // NoVideo
);
    // ==========================================
    // Age of the last frame boundary
    logic vs_d_r;
    logic [3:0] vs_age_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vs_d_r <= 1'b0;
            vs_age_r <= 4'hf;
        end
        else
        begin
            vs_d_r <= vsync_in;
            if (vsync_in && !vs_d_r)
                vs_age_r <= 4'h0;
            else if (vs_age_r != 4'hf)
                vs_age_r <= vs_age_r + 4'h1;
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_after_two;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    chk_write_answer: assert property (aw_w_taken |=> b_after_two)
        else $error("write response not two cycles after request");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before ready");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after request");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held until ready");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_cfg_toggle: assert property ($changed(cfg_out) == $changed(cfg_toggle))
        else $error("toggle does not follow settings change");
    chk_srst_pulse: assert property (stream_reset != 4'h0 |=> stream_reset == 4'h0)
        else $error("stream reset longer than one cycle");
    chk_scr_pulse: assert property (scrambler_restart |=> !scrambler_restart)
        else $error("scrambler reset longer than one cycle");
    chk_stuff_level: assert property (send_stuffing == !bits_out.link_en)
        else $error("stuffing does not match link enable");
    chk_novideo_en: assert property (send_novideo |-> bits_out.link_en)
        else $error("novideo while link disabled");
    chk_frame_gate: assert property ($changed(send_novideo) && $stable(bits_out.link_en) |-> vs_age_r <= 4'h6)
        else $error("video enable applied away from frame boundary");
endmodule

bind tlc_regs tlc_regs_chk u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .vsync_in, .cfg_out, .cfg_toggle, .bits_out, .stream_reset,
    .scrambler_restart, .send_stuffing, .send_novideo);

// >>> sim/tb_top.sv
// Self-checking testbench of the transmitter link config bank
`timescale 1ns/100ps
module tb_top;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tgl;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb, stream_reset, srst_seen;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic vsync_in, vcp_updated_in, cfg_toggle, scrambler_restart, scr_seen, seen_clr;
    logic send_stuffing, send_novideo;
    logic [7:0] rates [3] = '{8'h0a, 8'h14, 8'h06};
    logic [11:0] offs [4] = '{12'h008, 12'h014, 12'h018, 12'h088};
    tlc_pkg::tlc_cfg_t cfg_out;
    tlc_pkg::tlc_bits_t bits_out;
    int n_errors, tests_run;

    tlc_regs dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .vsync_in, .vcp_updated_in, .cfg_out, .cfg_toggle,
        .bits_out, .stream_reset, .scrambler_restart, .send_stuffing, .send_novideo);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Collects one-cycle pulses between checks
    always @(posedge clk)
    begin
        srst_seen <= seen_clr ? 4'h0 : srst_seen | stream_reset;
        scr_seen <= seen_clr ? 1'b0 : scr_seen | scrambler_restart;
    end

    // ==========================================
    // Bus tasks
    task tick;
        @(posedge clk);
        #1;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr = {20'h0, a};
        s_axi_wdata = d;
        s_axi_awvalid = 1'b1;
        s_axi_wvalid = 1'b1;
        while (!(s_axi_awready && s_axi_wready))
            tick();
        tick();
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        while (!s_axi_bvalid)
            tick();
        tick();
        s_axi_bready = 1'b1;
        chk(32'(s_axi_bresp), 32'(er));
        tick();
        s_axi_bready = 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr = {20'h0, a};
        s_axi_arvalid = 1'b1;
        while (!s_axi_arready)
            tick();
        tick();
        s_axi_arvalid = 1'b0;
        while (!s_axi_rvalid)
            tick();
        tick();
        s_axi_rready = 1'b1;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        tick();
        s_axi_rready = 1'b0;
    endtask

    task vs_pulse;
        vsync_in = 1'b1;
        repeat (3) tick();
        vsync_in = 1'b0;
        repeat (8) tick();
    endtask

    task end_sim;
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #40000;
        n_errors++;
        end_sim();
    end

    // ==========================================
    // Tests
    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, vsync_in, vcp_updated_in} = '0;
        s_axi_wstrb = 4'hf;
        {n_errors, tests_run} = '0;
        seen_clr = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        seen_clr = 1'b0;
        rd(12'h000, 32'h06, 2'h0);
        rd(12'h004, 32'h01, 2'h0);
        rd(12'h0e0, 32'h55555555, 2'h0);
        chk(32'(send_stuffing), 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(12'h000, {24'hffffff, rates[i]}, 2'h0);
            rd(12'h000, {24'h0, rates[i]}, 2'h0);
            chk(32'(cfg_out.rate), 32'(rates[i]));
            tgl = cfg_toggle;
            wr(12'h004, 32'hffffffe0 | (32'h1 << (i + 1) % 3), 2'h0);
            rd(12'h004, 32'h1 << (i + 1) % 3, 2'h0);
            chk(32'(cfg_out.lanes), 32'h1 << (i + 1) % 3);
            chk(32'(cfg_toggle), 32'(!tgl));
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(12'h00c, 32'hfffffffc | i, 2'h0);
            wr(12'h010, 32'hfffffffc | (3 - i), 2'h0);
            rd(12'h00c, i, 2'h0);
            rd(12'h010, 3 - i, 2'h0);
            chk({cfg_out.train, cfg_out.qual}, (i << 2) | (3 - i));
        end
        for (int v = 1; v >= 0; v--)
        begin
            for (int k = 0; k < 4; k++)
            begin
                wr(offs[k], 32'hfffffffe | v, 2'h0);
                rd(offs[k], v, 2'h0);
            end
            chk({bits_out.enh_frame, bits_out.scr_bypass, bits_out.spread, bits_out.side_en},
                {4{v[0]}});
        end
        wr(12'h01c, 32'h5, 2'h0);
        chk(32'(srst_seen), 32'h5);
        seen_clr = 1'b1;
        tick();
        seen_clr = 1'b0;
        wr(12'h01c, 32'hfffffffa, 2'h0);
        chk(32'(srst_seen), 32'ha);
        rd(12'h01c, 32'h0, 2'h0);
        wr(12'h0c0, 32'h1, 2'h0);
        chk(32'(scr_seen), 32'h1);
        rd(12'h0c0, 32'h0, 2'h0);
        wr(12'h080, 32'h1, 2'h0);
        chk({send_stuffing, send_novideo}, 32'h1);
        wr(12'h084, 32'h1, 2'h0);
        chk(32'(bits_out.vid_en), 32'h1);
        repeat (8) tick();
        chk(32'(send_novideo), 32'h1);
        vs_pulse();
        chk(32'(send_novideo), 32'h0);
        wr(12'h084, 32'h0, 2'h0);
        vs_pulse();
        chk(32'(send_novideo), 32'h1);
        wr(12'h080, 32'h0, 2'h0);
        chk(32'(send_stuffing), 32'h1);
        wr(12'h0d0, 32'hfffffffd, 2'h0);
        rd(12'h0d0, 32'h1, 2'h0);
        chk(32'(bits_out.mst_en), 32'h1);
        vcp_updated_in = 1'b1;
        repeat (5) tick();
        rd(12'h0d0, 32'h3, 2'h0);
        vcp_updated_in = 1'b0;
        wr(12'h0d0, 32'h0, 2'h0);
        rd(12'h0d0, 32'h0, 2'h0);
        wr(12'h0e0, 32'h1c2c3c4c, 2'h0);
        rd(12'h0e0, 32'h1c2c3c4c, 2'h0);
        chk(cfg_out.pixw, 32'h1c2c3c4c);
        s_axi_wstrb = 4'h2;
        wr(12'h0e0, 32'hffff99ff, 2'h0);
        rd(12'h0e0, 32'h1c2c994c, 2'h0);
        wr(12'h008, 32'hffffffff, 2'h0);
        rd(12'h008, 32'h0, 2'h0);
        s_axi_wstrb = 4'hf;
        wr(12'h040, 32'hffffffff, 2'h2);
        rd(12'h040, 32'h0, 2'h2);
        end_sim();
    end
endmodule
